// [display_port_group.sv]
// Display-capable general-purpose port group with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none

// Contract
// [RULE_01] First display port: eight output-only pins, output after reset, latch drives pins.
// [RULE_02] Second display port: eight output-only pins, no direction control, output after reset.
// [RULE_03] Third display port: each pin direction set by its own bit; reset selects input.
// [RULE_04] Fourth display port: one direction bit per pin; reset makes every pin input.
// [RULE_05] Fifth display port: per-bit direction; reset makes whole port input.
// [RULE_06] All five display ports can hand their pins to the display driver outputs.
// [RULE_07] Each direction register writable alone, whole byte or single bit.
// [RULE_08] Five-pin port direction registers reset to 1FH, all others to FFH.
// [RULE_09] Driven level change on an interrupt-capable output pin sets its request flag.
// [RULE_10] Software masks the pin's interrupt before switching it to output.
// [RULE_11] Interrupt port bits zero and four are input-only, direction fixed at input.
// [RULE_12] Software sets direction to input before using an alternate input function.
// [RULE_13] Software clears direction and latch before using an alternate output function.
// [RULE_14] Reading subclock pin or analog port in alternate mode gives undefined data.
// [RULE_15] Display port latches stay writable while the display driver runs.
// [RULE_16] Direction bit 0 turns output buffer on; 1 turns it off.
// [RULE_17] Write in input mode updates latch but leaves pin undriven.
// [RULE_18] Read returns pin level in input mode, latch in output mode; latch unchanged.
// [RULE_19] Direction bit n controls only pin n of its own port.
module display_port_group #(
   parameter int ADDR_W = port_group_pkg::AXI_ADDR_W
) (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [port_group_pkg::DATA_W-1:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [port_group_pkg::DATA_W-1:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   input wire logic [4:0] P0_PIN_I,
   output port_group_pkg::pin_drive_t P0_PIN_O,
   input wire logic [7:0] P1_PIN_I,
   output port_group_pkg::pin_drive_t P1_PIN_O,
   input wire logic [4:0] P7_PIN_I,
   output port_group_pkg::pin_drive_t P7_PIN_O,
   output logic [7:0] P8_PIN_O,
   output logic [7:0] P9_PIN_O,
   input wire logic [7:0] P10_PIN_I,
   output port_group_pkg::pin_drive_t P10_PIN_O,
   input wire logic [7:0] P11_PIN_I,
   output port_group_pkg::pin_drive_t P11_PIN_O,
   input wire logic [7:0] P12_PIN_I,
   output port_group_pkg::pin_drive_t P12_PIN_O,
   input wire port_group_pkg::disp_seg_t DISP_SEG_I,
   output logic IRQ_O
);
   import port_group_pkg::*;
   // ********************************************************************
   // Declarations
   // ********************************************************************
   logic [7:0] pin_raw [NSLOT], sync1_q [NSLOT], sync2_q [NSLOT];
   logic [7:0] latch_q [NSLOT], dir_q [NSLOT], pin_val [NSLOT];
   pin_drive_t drive_q [NSLOT];
   logic [NDISP-1:0][7:0] seg_arr;
   logic [NDISP-1:0] disp_ctrl_q;
   logic [IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_lvl, irq_lvl_prev_q;
   logic [1:0] alt_ctrl_q, arm_cnt_q, bresp_q, rresp_q;
   logic irq_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic wr_fire, wr_en, rd_take, rd_stat_clr;
   logic [DATA_W-1:0] rdata_q, wdata_q, rd_word;
   logic [ADDR_W-1:0] awaddr_q;
   logic [3:0] wstrb_q;
   logic [7:0] wr_mask;
   reg_dec_t wdec, rdec;

   // ********************************************************************
   // Address decode, shared by the read and the write path
   // ********************************************************************
   function automatic reg_dec_t decode(input logic [ADDR_W-1:0] addr);
      reg_dec_t d;
      d = '0;
      d.idx = 16'(addr >> 2);
      for (int s = 0; s < NSLOT; s++) begin
         if (d.idx == IDX_LATCH[s]) begin
            d.hit = 1'b1;
            d.is_latch = 1'b1;
            d.slot = 3'(s);
         end
         if (HAS_DIR[s] && d.idx == IDX_DIR[s]) begin
            d.hit = 1'b1;
            d.is_dir = 1'b1;
            d.slot = 3'(s);
         end
      end
      if (d.idx == IDX_DISP_CTRL || d.idx == IDX_ALT_CTRL ||
          d.idx == IDX_IRQ_STAT || d.idx == IDX_IRQ_MASK) begin
         d.hit = 1'b1;
      end
      return d;
   endfunction : decode
   // ********************************************************************
   // Pin inputs gathered per slot; output-only ports have none
   // ********************************************************************
   assign pin_raw[0] = {3'h0, P0_PIN_I};
   assign pin_raw[1] = P1_PIN_I;
   assign pin_raw[2] = {3'h0, P7_PIN_I};
   assign pin_raw[3] = 8'h00;
   assign pin_raw[4] = 8'h00;
   assign pin_raw[5] = P10_PIN_I;
   assign pin_raw[6] = P11_PIN_I;
   assign pin_raw[7] = P12_PIN_I;
   assign seg_arr = DISP_SEG_I;
   // ********************************************************************
   // Write-side strobes
   // ********************************************************************
   // Both address and data held, no response pending: commit this cycle
   assign wr_fire = !awready_q && !wready_q && !bvalid_q;
   assign wdec = decode(awaddr_q);
   assign wr_en = wr_fire && wdec.hit && wstrb_q[LANE_DATA];
   // Lane 1 carries a bit-select mask for single-bit manipulation
   assign wr_mask = wstrb_q[LANE_BITSEL] ? wdata_q[15:8] : FULL_BYTE; // [RULE_07]
   assign rd_take = S_AXI_ARVALID_I && arready_q;
   assign rdec = decode(S_AXI_ARADDR_I);

   // ********************************************************************
   // Per-slot port logic
   // ********************************************************************
   generate
      for (genvar s = 0; s < NSLOT; s++) begin : g_slot
         // Two-flop synchroniser; nothing looks at the first stage
         always_ff @(posedge CLK_I) begin
            sync1_q[s] <= pin_raw[s];
            sync2_q[s] <= sync1_q[s];
         end

         // Output latch; writes land in any mode, display running or not
         always_ff @(posedge CLK_I) begin
            if (SYS_RST_I) begin
               latch_q[s] <= LATCH_RST;
            end else if (wr_en && wdec.is_latch && wdec.slot == 3'(s)) begin
               latch_q[s] <= ((latch_q[s] & ~wr_mask) | (wdata_q[7:0] & wr_mask))
                             & PIN_MASK[s]; // [RULE_15] [RULE_17]
            end
         end

         // Direction register; fixed bits forced on every write
         always_ff @(posedge CLK_I) begin
            if (SYS_RST_I) begin
               dir_q[s] <= DIR_RST[s]; // [RULE_01] [RULE_02] [RULE_08] [RULE_03] [RULE_04] [RULE_05]
            end else if (wr_en && wdec.is_dir && wdec.slot == 3'(s)) begin
               dir_q[s] <= (((dir_q[s] & ~wr_mask) | (wdata_q[7:0] & wr_mask))
                            | DIR_FIX1[s]) & ~DIR_FIX0[s]; // [RULE_07] [RULE_11] [RULE_19]
            end
         end

         // Input-mode bits read the pin, output-mode bits read the latch
         assign pin_val[s] = (dir_q[s] & sync2_q[s]) | (~dir_q[s] & latch_q[s]); // [RULE_18]

         // Pin drive; registered so the pins come straight from flops
         if (s >= FIRST_DISP_SLOT) begin : g_disp
            always_ff @(posedge CLK_I) begin
               if (SYS_RST_I) begin
                  drive_q[s] <= '{out: LATCH_RST, oe: ~DIR_RST[s]};
               end else begin
                  drive_q[s].out <= disp_ctrl_q[s - FIRST_DISP_SLOT] ?
                                    seg_arr[s - FIRST_DISP_SLOT] : latch_q[s]; // [RULE_06]
                  drive_q[s].oe <= ~dir_q[s] & PIN_MASK[s]; // [RULE_16] [RULE_03]
               end
            end
         end else begin : g_gp
            always_ff @(posedge CLK_I) begin
               if (SYS_RST_I) begin
                  drive_q[s] <= '{out: LATCH_RST, oe: ~DIR_RST[s] & PIN_MASK[s]};
               end else begin
                  drive_q[s].out <= latch_q[s];
                  drive_q[s].oe <= ~dir_q[s] & PIN_MASK[s]; // [RULE_16] [RULE_11]
               end
            end
         end
      end
   endgenerate
   // ********************************************************************
   // Loose control registers
   // ********************************************************************
   // Display takeover, alternate-input enables and interrupt mask
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         disp_ctrl_q <= DISP_CTRL_RST;
         alt_ctrl_q <= ALT_CTRL_RST;
         irq_mask_q <= IRQ_MASK_RST;
      end else if (wr_en) begin
         if (wdec.idx == IDX_DISP_CTRL) begin
            disp_ctrl_q <= wdata_q[NDISP-1:0]; // [RULE_06]
         end
         if (wdec.idx == IDX_ALT_CTRL) begin
            alt_ctrl_q <= wdata_q[1:0];
         end
         if (wdec.idx == IDX_IRQ_MASK) begin
            irq_mask_q <= wdata_q[IRQ_W-1:0];
         end
      end
   end

   // ********************************************************************
   // Interrupt-capable port: level change detection
   // ********************************************************************
   // Watch the level the pin really carries: latch when driven, pin otherwise
   always_comb begin
      for (int b = 0; b < IRQ_W; b++) begin
         irq_lvl[b] = dir_q[SLOT_IRQ][b] ? sync2_q[SLOT_IRQ][b] : latch_q[SLOT_IRQ][b];
      end
   end

   // Arm only after the synchroniser has filled, to avoid a flag at reset
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         arm_cnt_q <= 2'h0;
      end else if (arm_cnt_q != 2'(ARM_CYCLES)) begin
         arm_cnt_q <= arm_cnt_q + 2'h1;
      end
   end

   always_ff @(posedge CLK_I) begin
      irq_lvl_prev_q <= irq_lvl;
   end

   // Read of the status register clears it; a new event in that cycle wins
   assign rd_stat_clr = rd_take && rdec.idx == IDX_IRQ_STAT;
   always_comb begin
      irq_stat_d = irq_stat_q & ~(rd_stat_clr ? {IRQ_W{1'b1}} : {IRQ_W{1'b0}});
      if (arm_cnt_q == 2'(ARM_CYCLES)) begin
         irq_stat_d = irq_stat_d | (irq_lvl ^ irq_lvl_prev_q); // [RULE_09]
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         irq_stat_q <= '0;
         irq_q <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq_q <= |(irq_stat_q & ~irq_mask_q); // Mask bit 1 blocks the request
      end
   end

   // ********************************************************************
   // Read data mux
   // ********************************************************************
   always_comb begin
      rd_word = '0;
      if (rdec.is_latch) begin
         rd_word[7:0] = pin_val[rdec.slot];
         // Alternate-function pins read as zero; software must not rely on it
         if (rdec.slot == SLOT_IRQ && alt_ctrl_q[ALT_SUBCLK_BIT]) begin
            rd_word[SUBCLK_PIN] = 1'b0; // [RULE_14]
         end
         if (rdec.slot == SLOT_ANALOG && alt_ctrl_q[ALT_ANALOG_BIT]) begin
            rd_word[7:0] = 8'h00; // [RULE_14]
         end
      end else if (rdec.is_dir) begin
         rd_word[7:0] = dir_q[rdec.slot];
      end else if (rdec.idx == IDX_DISP_CTRL) begin
         rd_word[NDISP-1:0] = disp_ctrl_q;
      end else if (rdec.idx == IDX_ALT_CTRL) begin
         rd_word[1:0] = alt_ctrl_q;
      end else if (rdec.idx == IDX_IRQ_STAT) begin
         rd_word[IRQ_W-1:0] = irq_stat_q;
      end else if (rdec.idx == IDX_IRQ_MASK) begin
         rd_word[IRQ_W-1:0] = irq_mask_q;
      end
   end

   // ********************************************************************
   // AXI4-Lite write channels
   // ********************************************************************
   // Address and data are taken in either order, then held until the response
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         awready_q <= 1'b1;
         awaddr_q <= '0;
      end else if (S_AXI_AWVALID_I && awready_q) begin
         awready_q <= 1'b0;
         awaddr_q <= S_AXI_AWADDR_I;
      end else if (bvalid_q && S_AXI_BREADY_I) begin
         awready_q <= 1'b1;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         wready_q <= 1'b1;
         wdata_q <= '0;
         wstrb_q <= 4'h0;
      end else if (S_AXI_WVALID_I && wready_q) begin
         wready_q <= 1'b0;
         wdata_q <= S_AXI_WDATA_I;
         wstrb_q <= S_AXI_WSTRB_I;
      end else if (bvalid_q && S_AXI_BREADY_I) begin
         wready_q <= 1'b1;
      end
   end

   // Unmapped addresses answer with a slave error and change nothing
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wdec.hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY_I) begin
         bvalid_q <= 1'b0;
      end
   end

   // ********************************************************************
   // AXI4-Lite read channels
   // ********************************************************************
   // Reads never touch a latch; only the status register clears on read
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= '0;
      end else if (rd_take) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= rdec.hit ? RESP_OKAY : RESP_SLVERR;
         rdata_q <= rd_word; // [RULE_18]
      end else if (rvalid_q && S_AXI_RREADY_I) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
      end
   end

   // ********************************************************************
   // Outputs, all from flops
   // ********************************************************************
   assign S_AXI_AWREADY_O = awready_q;
   assign S_AXI_WREADY_O = wready_q;
   assign S_AXI_BVALID_O = bvalid_q;
   assign S_AXI_BRESP_O = bresp_q;
   assign S_AXI_ARREADY_O = arready_q;
   assign S_AXI_RVALID_O = rvalid_q;
   assign S_AXI_RRESP_O = rresp_q;
   assign S_AXI_RDATA_O = rdata_q;
   assign P0_PIN_O = drive_q[0];
   assign P1_PIN_O = drive_q[1];
   assign P7_PIN_O = drive_q[2];
   assign P8_PIN_O = drive_q[3].out; // [RULE_01]
   assign P9_PIN_O = drive_q[4].out; // [RULE_02]
   assign P10_PIN_O = drive_q[5];
   assign P11_PIN_O = drive_q[6];
   assign P12_PIN_O = drive_q[7];
   assign IRQ_O = irq_q;
endmodule : display_port_group

`default_nettype wire

// [display_port_group_tb.sv]
// Self-checking bench for the display port group
`timescale 1ns/1ps
`default_nettype none
module display_port_group_tb;
   import port_group_pkg::*;
   typedef struct packed {
      logic w;
      logic [15:0] ix;
      logic [15:0] d;
      logic [3:0] s;
      logic [1:0] rs;
      logic [7:0] e;
   } row_t;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [17:0] awa = 18'h00000, ara = 18'h00000;
   logic [31:0] wd = 32'h00000000, d, rd;
   logic [3:0] ws = 4'h0;
   logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
   logic awr, wrdy, bv, arr, rv, irq;
   logic [1:0] br, rr, r;
   logic [7:0] p8, p9;
   logic [7:0] ex [6] = '{8'h00, 8'h5C, 8'h0A, 8'h96, 8'hF0, 8'hA0};
   logic [7:0] pi [6];
   pin_drive_t pd [6];
   disp_seg_t seg = 40'h3CE1C69669;
   int fail_count = 0;
   int tests_run = 0;
   row_t rows [10] = '{'{1'h0, 16'hFF20, 16'h0000, 4'h0, RESP_OKAY, 8'h1F},
      '{1'h0, 16'hFF27, 16'h0000, 4'h0, RESP_OKAY, 8'h1F},
      '{1'h0, 16'hFF2A, 16'h0000, 4'h0, RESP_OKAY, 8'hFF},
      '{1'h1, 16'hFF20, 16'h0000, 4'h1, RESP_OKAY, 8'h11},
      '{1'h1, 16'hFF2A, 16'h0000, 4'h1, RESP_OKAY, 8'h00},
      '{1'h1, 16'hFF2B, 16'h0400, 4'h3, RESP_OKAY, 8'hFB},
      '{1'h1, 16'hFF0A, 16'h005A, 4'h1, RESP_OKAY, 8'h5A},
      '{1'h1, 16'hFF08, 16'h00C3, 4'h1, RESP_OKAY, 8'hC3},
      '{1'h1, 16'hFF28, 16'h0055, 4'h1, RESP_SLVERR, 8'h00},
      '{1'h1, 16'hFF09, 16'h0033, 4'h0, RESP_OKAY, 8'h00}};
   always #4 clk = ~clk;
   display_port_group i_dut (.CLK_I(clk), .SYS_RST_I(rst),
      .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
      .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
      .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
      .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
      .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
      .P0_PIN_I(pi[0][4:0]), .P0_PIN_O(pd[0]), .P1_PIN_I(pi[1]), .P1_PIN_O(pd[1]),
      .P7_PIN_I(pi[2][4:0]), .P7_PIN_O(pd[2]), .P8_PIN_O(p8), .P9_PIN_O(p9),
      .P10_PIN_I(pi[3]), .P10_PIN_O(pd[3]), .P11_PIN_I(pi[4]), .P11_PIN_O(pd[4]),
      .P12_PIN_I(pi[5]), .P12_PIN_O(pd[5]), .DISP_SEG_I(seg), .IRQ_O(irq));
   // Board wiring for the six bidirectional ports
   for (genvar k = 0; k < 6; k++) begin : g_pins
      pin_world i_pw (.drive_i(pd[k]), .ext_i(ex[k]), .pin_o(pi[k]));
   end
   // Ready is looked at on the falling edge and acted on at the next rise
   task automatic axi_wr(input logic [15:0] ix, input logic [15:0] v, input logic [3:0] s);
      logic a, w, b;
      b = 1'h0;
      @(posedge clk);
      awa <= {ix, 2'h0};
      wd <= {16'h0000, v};
      ws <= s;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      while (!b) begin
         @(negedge clk);
         a = awv && awr;
         w = wv && wrdy;
         b = bv;
         r = br;
         @(posedge clk);
         if (a) awv <= 1'h0;
         if (w) wv <= 1'h0;
      end
      bry <= 1'h0;
   endtask : axi_wr
   task automatic axi_rd(input logic [15:0] ix);
      logic a, b;
      b = 1'h0;
      @(posedge clk);
      ara <= {ix, 2'h0};
      arv <= 1'h1;
      rry <= 1'h1;
      while (!b) begin
         @(negedge clk);
         a = arv && arr;
         b = rv;
         d = rd;
         r = rr;
         @(posedge clk);
         if (a) arv <= 1'h0;
      end
      rry <= 1'h0;
   endtask : axi_rd
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic get(input string nm, input logic [15:0] ix, input logic [7:0] e);
      axi_rd(ix);
      chk(nm, 32'(e), d);
   endtask : get
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop
   // Main sequence: table first, then pins, display, interrupts and a second reset
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      foreach (rows[k]) begin
         if (rows[k].w) begin
            axi_wr(rows[k].ix, rows[k].d, rows[k].s);
            chk("bresp", 32'(rows[k].rs), 32'(r));
         end
         axi_rd(rows[k].ix);
         chk("rresp", 32'(rows[k].rs), 32'(r));
         chk("rdata", 32'(rows[k].e), d);
      end
      @(negedge clk);
      chk("p8", 32'h000000C3, 32'(p8));
      chk("p10", 32'h00005AFF, 32'(pd[3]));
      axi_wr(16'hFF0B, 16'h00A5, 4'h1);
      @(negedge clk);
      chk("p11", 32'h0000A504, 32'(pd[4]));
      get("p11 rd", 16'hFF0B, 8'hF4);
      axi_wr(16'hFF40, 16'h001F, 4'h1);
      @(negedge clk);
      chk("p8 seg", 32'(seg.p8), 32'(p8));
      chk("p9 seg", 32'(seg.p9), 32'(p9));
      chk("p10 seg", {16'h0000, seg.p10, 8'hFF}, 32'(pd[3]));
      chk("p12 seg", {16'h0000, seg.p12, 8'h00}, 32'(pd[5]));
      axi_wr(16'hFF0A, 16'h0077, 4'h1);
      get("p10 latch", 16'hFF0A, 8'h77);
      axi_wr(16'hFF40, 16'h0000, 4'h1);
      @(negedge clk);
      chk("p10 back", 32'h000077FF, 32'(pd[3]));
      axi_wr(16'hFF41, 16'h0002, 4'h1);
      get("alt", 16'hFF01, 8'h00);
      axi_rd(16'hFF42);
      axi_wr(16'hFF43, 16'h0000, 4'h1);
      axi_wr(16'hFF00, 16'h0002, 4'h1);
      repeat (3) @(negedge clk);
      chk("irq up", 32'h00000001, 32'(irq));
      chk("p0", 32'h0000020E, 32'(pd[0]));
      get("stat", 16'hFF42, 8'h02);
      repeat (2) @(negedge clk);
      chk("irq clr", 32'h00000000, 32'(irq));
      axi_wr(16'hFF43, 16'h000F, 4'h1);
      axi_wr(16'hFF00, 16'h0000, 4'h1);
      ex[0] <= 8'h01;
      repeat (5) @(negedge clk);
      chk("irq mask", 32'h00000000, 32'(irq));
      get("stat mask", 16'hFF42, 8'h03);
      axi_wr(16'hFF09, 16'h0033, 4'h1);
      rst <= 1'h1;
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      @(negedge clk);
      chk("p9 rst", 32'h00000000, 32'(p9));
      chk("p10 rst", 32'h00000000, 32'(pd[3]));
      get("dir rst", 16'hFF2C, 8'hFF);
      report_and_stop();
   end
   // Watchdog, well beyond the fewer than two hundred cycles the sequence needs
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
endmodule : display_port_group_tb
`default_nettype wire

// [pin_world.sv]
// Model of the board wiring seen by one bidirectional port
`timescale 1ns/1ps
`default_nettype none
module pin_world (
   input wire port_group_pkg::pin_drive_t drive_i,
   input wire logic [7:0] ext_i,
   output logic [7:0] pin_o
);
   import port_group_pkg::*;
   // Driven bits show drive_i.out, latch or display segment; released bits show the outside source
   assign pin_o = (drive_i.out & drive_i.oe) | (ext_i & ~drive_i.oe);
endmodule : pin_world
`default_nettype wire

// [port_group_monitor.sv]
// Timing checker bound to the display port group
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module port_group_monitor (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic S_AXI_AWVALID_I,
   input wire logic S_AXI_AWREADY_O,
   input wire logic S_AXI_WVALID_I,
   input wire logic S_AXI_WREADY_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic [port_group_pkg::DATA_W-1:0] S_AXI_RDATA_O,
   input wire port_group_pkg::pin_drive_t P0_PIN_O,
   input wire port_group_pkg::pin_drive_t P1_PIN_O,
   input wire port_group_pkg::pin_drive_t P7_PIN_O,
   input wire port_group_pkg::pin_drive_t P10_PIN_O,
   input wire port_group_pkg::pin_drive_t P11_PIN_O,
   input wire port_group_pkg::pin_drive_t P12_PIN_O,
   input wire logic [7:0] P8_PIN_O,
   input wire logic [7:0] P9_PIN_O,
   input wire logic IRQ_O
);
   import port_group_pkg::*;
   // One clock domain, so checks pause together while reset is high
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (SYS_RST_I);
   // All enables in one vector, so a stray change anywhere is caught
   wire logic [47:0] all_oe = {P0_PIN_O.oe, P1_PIN_O.oe, P7_PIN_O.oe,
                               P10_PIN_O.oe, P11_PIN_O.oe, P12_PIN_O.oe};
   property p_rst_out;
      $fell(SYS_RST_I) |-> P8_PIN_O == 8'h00 && P9_PIN_O == 8'h00;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("Out port not cleared");
   property p_rst_dir;
      $fell(SYS_RST_I) |-> all_oe == 48'h000000000000;
   endproperty
   a_rst_dir: assert property (p_rst_dir) else $error("Pin driven after reset");
   property p_fixed_in;
      P0_PIN_O.oe[0] == 1'h0 && P0_PIN_O.oe[4] == 1'h0 && P7_PIN_O.oe[7:5] == 3'h0;
   endproperty
   a_fixed_in: assert property (p_fixed_in) else $error("Input-only pin driven");
   property p_oe_cause;
      $changed(all_oe) |-> $past(S_AXI_BVALID_O);
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("Enable moved without write");
   property p_b_after;
      S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O |-> ##2 S_AXI_BVALID_O;
   endproperty
   a_b_after: assert property (p_b_after) else $error("Write answer late");
   property p_no_aw;
      S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O;
   endproperty
   a_no_aw: assert property (p_no_aw) else $error("Write taken during answer");
   property p_r_after;
      S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RDATA_O[31:8] == 24'h000000;
   endproperty
   a_r_after: assert property (p_r_after) else $error("Read upper bits set");
   property p_irq_quiet;
      $fell(SYS_RST_I) |-> !IRQ_O [*3];
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("Interrupt after reset");
endmodule : port_group_monitor
bind display_port_group port_group_monitor i_mon (.CLK_I, .SYS_RST_I, .S_AXI_AWVALID_I,
   .S_AXI_AWREADY_O, .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BVALID_O, .S_AXI_ARVALID_I,
   .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .P0_PIN_O, .P1_PIN_O, .P7_PIN_O, .P10_PIN_O,
   .P11_PIN_O, .P12_PIN_O, .P8_PIN_O, .P9_PIN_O, .IRQ_O);
`default_nettype wire

// [port_group_pkg.sv]
// Shared constants and types for the display-capable port group
package port_group_pkg;

   // ********************************************************************
   // Sizes
   // ********************************************************************
   localparam int AXI_ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int NSLOT = 8;
   localparam int NDISP = 5;
   localparam int IRQ_W = 4;
   localparam int ARM_CYCLES = 3;

   // ********************************************************************
   // Port slots: 0=irq port, 1=analog port, 2=five-pin port, 3..7=display
   // ********************************************************************
   localparam logic [2:0] SLOT_IRQ = 3'h0;
   localparam logic [2:0] SLOT_ANALOG = 3'h1;
   localparam int FIRST_DISP_SLOT = 3;

   // Register indices (byte address = 4 * index), slot 7 first
   localparam logic [7:0][15:0] IDX_LATCH = {16'hFF0C, 16'hFF0B, 16'hFF0A, 16'hFF09,
                                             16'hFF08, 16'hFF07, 16'hFF01, 16'hFF00};
   localparam logic [7:0][15:0] IDX_DIR = {16'hFF2C, 16'hFF2B, 16'hFF2A, 16'h0000,
                                           16'h0000, 16'hFF27, 16'hFF21, 16'hFF20};
   localparam logic [7:0] HAS_DIR = 8'hE7;
   localparam logic [15:0] IDX_DISP_CTRL = 16'hFF40;
   localparam logic [15:0] IDX_ALT_CTRL = 16'hFF41;
   localparam logic [15:0] IDX_IRQ_STAT = 16'hFF42;
   localparam logic [15:0] IDX_IRQ_MASK = 16'hFF43;

   // Per-slot reset values and fixed bits of the direction registers
   localparam logic [7:0][7:0] DIR_RST = {8'hFF, 8'hFF, 8'hFF, 8'h00,
                                          8'h00, 8'h1F, 8'hFF, 8'h1F};
   localparam logic [7:0][7:0] DIR_FIX1 = {8'h00, 8'h00, 8'h00, 8'h00,
                                           8'h00, 8'h00, 8'h00, 8'h11};
   localparam logic [7:0][7:0] DIR_FIX0 = {8'h00, 8'h00, 8'h00, 8'hFF,
                                           8'hFF, 8'hE0, 8'h00, 8'hE0};
   localparam logic [7:0][7:0] PIN_MASK = {8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                           8'hFF, 8'h1F, 8'hFF, 8'h1F};
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [7:0] FULL_BYTE = 8'hFF;

   // Control fields
   localparam int ALT_SUBCLK_BIT = 0;
   localparam int ALT_ANALOG_BIT = 1;
   localparam int SUBCLK_PIN = 4;
   localparam logic [NDISP-1:0] DISP_CTRL_RST = 5'h00;
   localparam logic [1:0] ALT_CTRL_RST = 2'h0;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'hF;
   localparam int LANE_DATA = 0;
   localparam int LANE_BITSEL = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ********************************************************************
   // Types
   // ********************************************************************
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pin_drive_t;

   typedef struct packed {
      logic [7:0] p12;
      logic [7:0] p11;
      logic [7:0] p10;
      logic [7:0] p9;
      logic [7:0] p8;
   } disp_seg_t;

   typedef struct packed {
      logic hit;
      logic is_latch;
      logic is_dir;
      logic [2:0] slot;
      logic [15:0] idx;
   } reg_dec_t;

endpackage : port_group_pkg
